// File: ppcs_pkg.sv
// package: offsets, fields and reset values of the power-management registers
package ppcs_pkg;
    // printed offsets are not all multiples of four: they are word indices
    localparam logic [7:0] PPCS_IDX_CTRL_STATUS = 8'hA4;
    localparam logic [7:0] PPCS_IDX_BRIDGE_EXT = 8'hA6;
    localparam logic [9:0] PPCS_ADDR_CTRL_STATUS = {PPCS_IDX_CTRL_STATUS, 2'b00};
    localparam logic [9:0] PPCS_ADDR_BRIDGE_EXT = {PPCS_IDX_BRIDGE_EXT, 2'b00};
    // own registers
    localparam logic [9:0] PPCS_ADDR_EVENT_STATUS = 10'h2C0;
    localparam logic [9:0] PPCS_ADDR_RESET_COUNT = 10'h2C4;
    // field positions in the control/status word
    localparam int PPCS_BIT_WAKE_STATUS = 15;
    localparam int PPCS_BIT_WAKE_ENABLE = 8;
    localparam int PPCS_POS_POWER_STATE = 0;
    // field positions in the bridge extension byte
    localparam int PPCS_BIT_BUS_POWER_CLOCK_CTRL_ENABLE = 7;
    localparam int PPCS_BIT_D3_ACTION = 6;
    // reset values
    localparam logic [15:0] PPCS_CTRL_STATUS_RST = 16'h0000;
    localparam logic [7:0] PPCS_BRIDGE_EXT_RST = 8'hC0;
    // reset pulse length to the non-exempt register groups
    localparam logic [3:0] PPCS_GROUP_RESET_CYCLES = 4'h4;
    // axi responses
    localparam logic [1:0] PPCS_RESP_OKAY = 2'b00;
    localparam logic [1:0] PPCS_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0]
    {
        PPCS_D0 = 2'b00,
        PPCS_D1 = 2'b01,
        PPCS_D2 = 2'b10,
        PPCS_D3HOT = 2'b11
    } ppcs_power_t;
endpackage : ppcs_pkg

// File: ppcs_reset_pulse.sv
// module: one-shot reset pulse generator for the non-exempt register groups
`timescale 1ns/1ns
module ppcs_reset_pulse
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // trigger and pulse
    input wire logic trigger,
    output logic pulse,
    output logic [7:0] pulse_count
);
    logic [3:0] cnt_q;
    logic [7:0] count_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_q <= 4'h0;
        else if (trigger)
            cnt_q <= ppcs_pkg::PPCS_GROUP_RESET_CYCLES;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end

    // count of pulses, wraps; lets software see a wake reset happened
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_q <= 8'h00;
        else if (trigger)
            count_q <= count_q + 8'h01;
    end

    assign pulse = (cnt_q != 4'h0);
    assign pulse_count = count_q;
endmodule : ppcs_reset_pulse

// File: ppcs_top.sv
// module: power-management control/status register bank behind AXI4-Lite
`timescale 1ns/1ns
// Operation
// R1: the wake status flag sets on every wake event whatever the enable.
// R2: writing 1 to the wake status flag clears it and drops the wake request.
// R3: the wake request is driven only while the wake signal enable is set.
// R4: the power state field reads back the state and a write moves to it.
// R5: the D3hot-to-D0 internal reset leaves the control/status word alone.
// R6: leaving D3hot for D0 resets the config, legacy and CardBus groups.
// R7: vendor, power-management and legacy base registers are not reset.
// R8: the data scale field always reads zero.
// R9: the data select field always reads zero.
// R10: the dynamic data report enable bit always reads zero.
// R11: reserved bits 7-5 and 3-2 of the control/status word read zero.
// R12: the bus power/clock control enable bit reads one.
// R13: with bus power/clock control off, power state writes touch no bus.
// R14: the D3hot action bit picks power removal (0) or clock stop (1).
// R15: the D3hot action is honoured only while bus power/clock control is on.
// R16: bits 5-0 of the bridge extension byte read zero.
// R17: a write from D3hot to D0 issues one internal reset pulse.
module ppcs_top
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // function events
    input wire logic wake_event,
    // power-management outputs
    output logic wake_request,
    output logic [1:0] power_state,
    output logic group_reset,
    output logic secondary_clock_stop,
    output logic secondary_power_off
);
    logic [9:0] awaddr_q;
    logic aw_full_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_full_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wake_status_q;
    logic wake_enable_q;
    logic wake_req_q;
    ppcs_pkg::ppcs_power_t state_q;
    logic [7:0] reset_count;
    logic event_seen_q;
    logic do_write;
    logic wr_ctrl;
    logic wake_clear;
    logic state_write;
    logic leave_d3;
    logic bus_power_clock_ctrl_enable;
    logic d3_action;
    logic [15:0] ctrl_word;
    logic [7:0] bridge_byte;

    // byte lane test, used for the control/status word only
    function automatic logic lane(input logic [3:0] strb, input int idx);
        lane = strb[idx];
    endfunction : lane

    // decode of the four mapped words, shared by write and read paths
    function automatic logic mapped(input logic [9:0] addr);
        if (addr[9:2] == ppcs_pkg::PPCS_ADDR_CTRL_STATUS[9:2])
            mapped = 1'b1;
        else if (addr[9:2] == ppcs_pkg::PPCS_ADDR_BRIDGE_EXT[9:2])
            mapped = 1'b1;
        else if (addr[9:2] == ppcs_pkg::PPCS_ADDR_EVENT_STATUS[9:2])
            mapped = 1'b1;
        else if (addr[9:2] == ppcs_pkg::PPCS_ADDR_RESET_COUNT[9:2])
            mapped = 1'b1;
        else
            mapped = 1'b0;
    endfunction : mapped

    // write channels taken independently, then joined
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            awaddr_q <= 10'h000;
        end
        else if (s_axi_awvalid && !aw_full_q)
        begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (do_write)
            aw_full_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && !w_full_q)
        begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (do_write)
            w_full_q <= 1'b0;
    end

    assign wr_ctrl = do_write
        && (awaddr_q[9:2] == ppcs_pkg::PPCS_ADDR_CTRL_STATUS[9:2]);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= ppcs_pkg::PPCS_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            if (mapped(awaddr_q))
                bresp_q <= ppcs_pkg::PPCS_RESP_OKAY;
            else
                bresp_q <= ppcs_pkg::PPCS_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // control/status field updates
    assign wake_clear = wr_ctrl && lane(wstrb_q, 1)
        && wdata_q[ppcs_pkg::PPCS_BIT_WAKE_STATUS]; // R2
    assign state_write = wr_ctrl && lane(wstrb_q, 0);
    assign leave_d3 = state_write && (state_q == ppcs_pkg::PPCS_D3HOT)
        && (wdata_q[1:0] == ppcs_pkg::PPCS_D0); // R17

    // set wins over a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_status_q <= ppcs_pkg::PPCS_CTRL_STATUS_RST[15];
        else if (wake_event)
            wake_status_q <= 1'b1; // R1
        else if (wake_clear)
            wake_status_q <= 1'b0; // R2
    end

    // the group reset never feeds these flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_enable_q <= ppcs_pkg::PPCS_CTRL_STATUS_RST[8];
        else if (wr_ctrl && lane(wstrb_q, 1))
            wake_enable_q <= wdata_q[ppcs_pkg::PPCS_BIT_WAKE_ENABLE]; // R5
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= ppcs_pkg::PPCS_D0;
        else if (state_write)
            state_q <= ppcs_pkg::ppcs_power_t'(wdata_q[1:0]); // R4 R5
    end

    // wake request held until cleared or disabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_req_q <= 1'b0;
        else if (!wake_enable_q)
            wake_req_q <= 1'b0; // R3
        else if (wake_event)
            wake_req_q <= 1'b1; // R3
        else if (wake_clear)
            wake_req_q <= 1'b0; // R2
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            event_seen_q <= 1'b0;
        else if (wake_event)
            event_seen_q <= 1'b1;
    end

    assign wake_request = wake_req_q && wake_enable_q; // R3
    assign power_state = state_q;

    // only config, legacy socket and cardbus groups listen to this pulse
    ppcs_reset_pulse u_reset_pulse
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .trigger(leave_d3), // R6 R7 R17
        .pulse(group_reset),
        .pulse_count(reset_count)
    );

    // bridge extension byte is constant
    assign bus_power_clock_ctrl_enable = ppcs_pkg::PPCS_BRIDGE_EXT_RST[ppcs_pkg::PPCS_BIT_BUS_POWER_CLOCK_CTRL_ENABLE];
    assign d3_action =
        ppcs_pkg::PPCS_BRIDGE_EXT_RST[ppcs_pkg::PPCS_BIT_D3_ACTION];
    assign bridge_byte = {bus_power_clock_ctrl_enable, d3_action, 6'b00_0000}; // R12 R16

    // secondary bus action only when bus control is on
    assign secondary_clock_stop = bus_power_clock_ctrl_enable && d3_action
        && (state_q == ppcs_pkg::PPCS_D3HOT); // R13 R14 R15
    assign secondary_power_off = bus_power_clock_ctrl_enable && !d3_action
        && (state_q == ppcs_pkg::PPCS_D3HOT); // R13 R14 R15

    assign ctrl_word = {wake_status_q, 2'b00, 4'h0, wake_enable_q,
        3'b000, 1'b0, 2'b00, state_q}; // R8 R9 R10 R11

    // read channel, one outstanding
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= ppcs_pkg::PPCS_RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            if (mapped(s_axi_araddr))
                rresp_q <= ppcs_pkg::PPCS_RESP_OKAY;
            else
                rresp_q <= ppcs_pkg::PPCS_RESP_SLVERR;
            if (s_axi_araddr[9:2] == ppcs_pkg::PPCS_ADDR_CTRL_STATUS[9:2])
                rdata_q <= {16'h0000, ctrl_word};
            else if (s_axi_araddr[9:2] == ppcs_pkg::PPCS_ADDR_BRIDGE_EXT[9:2])
                rdata_q <= {24'h00_0000, bridge_byte};
            else if (s_axi_araddr[9:2]
                == ppcs_pkg::PPCS_ADDR_EVENT_STATUS[9:2])
                rdata_q <= {30'h0000_0000, group_reset, event_seen_q};
            else if (s_axi_araddr[9:2]
                == ppcs_pkg::PPCS_ADDR_RESET_COUNT[9:2])
                rdata_q <= {24'h00_0000, reset_count};
            else
                rdata_q <= 32'h0000_0000;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule : ppcs_top

// File: ppcs_checker_assertions.sv
// checker: port assertions for the power-management register bank
`timescale 1ns/1ns
module ppcs_checker
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    // power management
    input wire logic wake_event,
    input wire logic wake_request,
    input wire logic [1:0] power_state,
    input wire logic group_reset,
    input wire logic secondary_clock_stop,
    input wire logic secondary_power_off
);
    logic [9:0] rd_addr_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_addr_q <= s_axi_araddr;
    end
    wake_rise_a: assert property (
        $rose(wake_request) |-> $past(wake_event))
        else $error("wake request rose without an event");
    wake_fall_a: assert property (
        $fell(wake_request) |-> $rose(s_axi_bvalid))
        else $error("wake request fell without a write");
    state_write_a: assert property (
        $changed(power_state) |-> $rose(s_axi_bvalid))
        else $error("power state moved without a write");
    clock_stop_a: assert property (
        secondary_clock_stop == (power_state == ppcs_pkg::PPCS_D3HOT))
        else $error("clock stop disagrees with power state");
    power_off_a: assert property (
        !secondary_power_off)
        else $error("secondary power removed");
    reset_len_a: assert property (
        $rose(group_reset) |-> group_reset [*4] ##1 !group_reset)
        else $error("group reset length wrong");
    reset_cause_a: assert property (
        $rose(group_reset) |-> power_state == ppcs_pkg::PPCS_D0
        && $past(power_state, 2) == ppcs_pkg::PPCS_D3HOT)
        else $error("group reset without leaving D3hot");
    ctrl_zero_a: assert property (
        s_axi_rvalid && rd_addr_q == ppcs_pkg::PPCS_ADDR_CTRL_STATUS
        |-> (s_axi_rdata & 32'hFFFF7EFC) == 32'h0000_0000)
        else $error("read-only control bits not zero");
    bridge_byte_a: assert property (
        s_axi_rvalid && rd_addr_q == ppcs_pkg::PPCS_ADDR_BRIDGE_EXT
        |-> s_axi_rdata == 32'h0000_00C0)
        else $error("bridge byte wrong");
endmodule : ppcs_checker

// File: ppcs_wake_source.sv
// partner: wake event source standing for the card function
`timescale 1ns/1ns
module ppcs_wake_source
(
    // clock
    input wire logic aclk,
    // bench request and event out
    input wire logic fire,
    output logic wake_event
);
    logic [1:0] wait_q = 2'h0;
    logic armed_q = 1'b0;
    // random delay: a prompt or a slow function
    always_ff @(posedge aclk)
    begin
        wake_event <= 1'b0;
        if (fire)
        begin
            armed_q <= 1'b1;
            wait_q <= 2'($urandom_range(3));
        end
        else if (armed_q && wait_q == 2'h0)
        begin
            armed_q <= 1'b0;
            wake_event <= 1'b1;
        end
        else
            wait_q <= wait_q - 2'h1;
    end
endmodule : ppcs_wake_source

// File: testbench.sv
// testbench: register bus, power state and wake scenarios
`timescale 1ns/1ns
module testbench;
    localparam logic [9:0] ctl = ppcs_pkg::PPCS_ADDR_CTRL_STATUS;
    localparam logic [9:0] brg = ppcs_pkg::PPCS_ADDR_BRIDGE_EXT;
    localparam logic [1:0] ok = ppcs_pkg::PPCS_RESP_OKAY;
    logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0;
    logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, wake_event, wake_request, group_reset, stop, off;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_state;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [1:0] bexp = ppcs_pkg::PPCS_RESP_OKAY;
    int fail_count = 0, checks = 0, hi = 0;
    ppcs_top i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .wake_event(wake_event),
        .wake_request(wake_request), .power_state(power_state),
        .group_reset(group_reset), .secondary_clock_stop(stop),
        .secondary_power_off(off));
    ppcs_wake_source i_src (.aclk(aclk), .fire(fire),
        .wake_event(wake_event));
    initial forever #2 aclk = ~aclk;
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic finish_test;
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic tmo(input int n);
        if (n >= 60)
        begin
            fail_count++;
            finish_test();
        end
    endtask : tmo
    // awvalid and wvalid drop on their own ready edges
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        int n;
        bq.push_back(bexp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 60);
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [33:0] e);
        int n;
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 60);
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask : rd
    task automatic wake;
        @(posedge aclk);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask : wake
    always @(posedge aclk)
    begin
        hi += (group_reset === 1'b1);
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            cmp(34'(s_axi_bresp), 34'(bq.pop_front()));
    end
    initial
    begin
        void'($urandom(30));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ctl, 34'h0);
        rd(brg, 34'hC0);
        wr(brg, 32'h0);
        rd(brg, 34'hC0);
        rd(10'h100, {ppcs_pkg::PPCS_RESP_SLVERR, 32'h0});
        bexp = ppcs_pkg::PPCS_RESP_SLVERR;
        wr(10'h100, 32'hFFFF_FFFF);
        bexp = ok;
        for (int s = 0; s < 4; s++)
        begin
            wr(ctl, ($urandom & 32'hFFFF7EFC) | 32'(s));
            rd(ctl, 34'(s));
            cmp(34'(power_state), 34'(s));
            cmp(34'(stop), 34'(s == 3));
            cmp(34'(off), 34'h0);
        end
        wr(ctl, 32'h100);
        rd(ctl, 34'h100);
        wake();
        cmp(34'(wake_request), 34'h1);
        rd(ctl, 34'h8100);
        wr(ctl, 32'h8100);
        cmp(34'(wake_request), 34'h0);
        rd(ctl, 34'h100);
        wr(ctl, 32'h0);
        wake();
        cmp(34'(wake_request), 34'h0);
        rd(ctl, 34'h8000);
        wr(ctl, 32'h0);
        rd(ctl, 34'h8000);
        s_axi_wstrb <= 4'h1;
        wr(ctl, 32'h8102);
        rd(ctl, 34'h8002);
        s_axi_wstrb <= 4'hF;
        wr(ctl, 32'h8000);
        rd(ctl, 34'h0);
        rd(ppcs_pkg::PPCS_ADDR_EVENT_STATUS, 34'h1);
        rd(ppcs_pkg::PPCS_ADDR_RESET_COUNT, 34'h1);
        cmp(34'(hi), 34'h4);
        finish_test();
    end
endmodule : testbench
bind ppcs_top ppcs_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
    .wake_event(wake_event), .wake_request(wake_request),
    .power_state(power_state), .group_reset(group_reset),
    .secondary_clock_stop(secondary_clock_stop),
    .secondary_power_off(secondary_power_off));
